// >>> design/dpcl_host.sv
/*
 * Host controller for both ports of the dual-port memory: clears mailboxes after reset,
 * then runs user commands on each port. Assumes the memory pins are asynchronous.
 */
// Notes on behaviour
// - Left read of FFFE clears left flag
// - Right read of FFFF releases right flag
// - Controller clears both flags after power-up
// - Hold address until collision settles
// - Exactly one master per width array
// - Depth banks: AND collision indications
// - Token select acts as token chip select
`timescale 1ns/1ps
module dpcl_host
    import dpcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic init_done,
    input wire logic lft_cmd_valid,
    output logic lft_cmd_ready,
    input wire dpcl_cmd_type lft_cmd_kind,
    input wire logic [ADDR_W-1:0] lft_cmd_addr,
    input wire logic [DATA_W-1:0] lft_cmd_data,
    output logic lft_rsp_valid,
    output logic [DATA_W-1:0] lft_rsp_data,
    output logic lft_write_stalled,
    output logic lft_mail_pending,
    input wire logic rgt_cmd_valid,
    output logic rgt_cmd_ready,
    input wire dpcl_cmd_type rgt_cmd_kind,
    input wire logic [ADDR_W-1:0] rgt_cmd_addr,
    input wire logic [DATA_W-1:0] rgt_cmd_data,
    output logic rgt_rsp_valid,
    output logic [DATA_W-1:0] rgt_rsp_data,
    output logic rgt_write_stalled,
    output logic rgt_mail_pending,
    output logic role_select,
    output logic left_enable_n,
    output logic left_write_select_n,
    output logic left_out_enable_n,
    output logic left_token_select_n,
    output logic [ADDR_W-1:0] left_addr,
    output logic [DATA_W-1:0] left_data_out,
    output logic left_data_oe,
    input wire logic [DATA_W-1:0] left_data_in,
    input wire logic [BANKS-1:0] left_collision_n,
    input wire logic left_mailbox_flag_n,
    output logic right_enable_n,
    output logic right_write_select_n,
    output logic right_out_enable_n,
    output logic right_token_select_n,
    output logic [ADDR_W-1:0] right_addr,
    output logic [DATA_W-1:0] right_data_out,
    output logic right_data_oe,
    input wire logic [DATA_W-1:0] right_data_in,
    input wire logic [BANKS-1:0] right_collision_n,
    input wire logic right_mailbox_flag_n
);
    typedef enum logic [1:0] {
        INIT_ISSUE, INIT_WAIT, INIT_RUN
    } dpcl_init_type;

    dpcl_init_type init_state;
    logic lft_done, rgt_done;
    logic lft_valid, rgt_valid, lft_ready, rgt_ready;
    logic lft_rsp, rgt_rsp;
    dpcl_cmd_type lft_kind, rgt_kind;
    logic [ADDR_W-1:0] lft_addr_mux, rgt_addr_mux;
    logic lft_coll_any, rgt_coll_any;
    logic lft_flag_meta, lft_flag_sync, rgt_flag_meta, rgt_flag_sync;
    logic running;

    // This controller drives the one master of the array; slaves are strapped low
    assign role_select = 1'b1;

    // Depth banks each report collision; any low one counts
    assign lft_coll_any = &left_collision_n;
    assign rgt_coll_any = &right_collision_n;

    assign running = (init_state == INIT_RUN);
    assign init_done = running;

    // Power-up clear: each port reads its own mailbox once before users get the bus
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            init_state <= INIT_ISSUE;
            lft_done <= 1'b0;
            rgt_done <= 1'b0;
        end else begin
            unique case (init_state)
                INIT_ISSUE: begin
                    if (lft_ready && rgt_ready) begin
                        init_state <= INIT_WAIT;
                    end
                end
                INIT_WAIT: begin
                    if (lft_rsp) begin
                        lft_done <= 1'b1;
                    end
                    if (rgt_rsp) begin
                        rgt_done <= 1'b1;
                    end
                    if ((lft_done || lft_rsp) && (rgt_done || rgt_rsp)) begin
                        init_state <= INIT_RUN;
                    end
                end
                INIT_RUN: begin
                    init_state <= INIT_RUN;
                end
                // The unused code restarts the clear sequence
                default: begin
                    init_state <= INIT_ISSUE;
                end
            endcase
        end
    end

    // Init uses a memory read at the own mailbox, clearing the flag
    always_comb begin
        if (running) begin
            lft_valid = lft_cmd_valid;
            rgt_valid = rgt_cmd_valid;
            lft_kind = lft_cmd_kind;
            rgt_kind = rgt_cmd_kind;
            lft_addr_mux = lft_cmd_addr;
            rgt_addr_mux = rgt_cmd_addr;
        end else begin
            // Both clear reads start on one edge, so neither port sees the other half-done
            lft_valid = (init_state == INIT_ISSUE) && rgt_ready;
            rgt_valid = (init_state == INIT_ISSUE) && lft_ready;
            lft_kind = DPCL_MEM_READ;
            rgt_kind = DPCL_MEM_READ;
            lft_addr_mux = LEFT_MAILBOX_ADDR;
            rgt_addr_mux = RIGHT_MAILBOX_ADDR;
        end
    end
    assign lft_cmd_ready = running && lft_ready;
    assign rgt_cmd_ready = running && rgt_ready;
    assign lft_rsp_valid = running && lft_rsp;
    assign rgt_rsp_valid = running && rgt_rsp;

    // Mailbox flags are asynchronous pins; pending is the synchronised low level
    always_ff @(posedge ref_clk) begin
        lft_flag_meta <= left_mailbox_flag_n;
        lft_flag_sync <= lft_flag_meta;
        rgt_flag_meta <= right_mailbox_flag_n;
        rgt_flag_sync <= rgt_flag_meta;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lft_mail_pending <= 1'b0;
            rgt_mail_pending <= 1'b0;
        end else begin
            // Undefined flag level before the clear is hidden until init ends
            lft_mail_pending <= running && !lft_flag_sync;
            rgt_mail_pending <= running && !rgt_flag_sync;
        end
    end

    dpcl_port_seq u_left (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cmd_valid(lft_valid),
        .cmd_ready(lft_ready),
        .cmd_kind(lft_kind),
        .cmd_addr(lft_addr_mux),
        .cmd_data(lft_cmd_data),
        .rsp_valid(lft_rsp),
        .rsp_data(lft_rsp_data),
        .write_stalled(lft_write_stalled),
        .enable_n(left_enable_n),
        .write_select_n(left_write_select_n),
        .out_enable_n(left_out_enable_n),
        .token_select_n(left_token_select_n),
        .addr(left_addr),
        .data_out(left_data_out),
        .data_oe(left_data_oe),
        .data_in(left_data_in),
        .collision_n(lft_coll_any)
    );

    dpcl_port_seq u_right (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cmd_valid(rgt_valid),
        .cmd_ready(rgt_ready),
        .cmd_kind(rgt_kind),
        .cmd_addr(rgt_addr_mux),
        .cmd_data(rgt_cmd_data),
        .rsp_valid(rgt_rsp),
        .rsp_data(rgt_rsp_data),
        .write_stalled(rgt_write_stalled),
        .enable_n(right_enable_n),
        .write_select_n(right_write_select_n),
        .out_enable_n(right_out_enable_n),
        .token_select_n(right_token_select_n),
        .addr(right_addr),
        .data_out(right_data_out),
        .data_oe(right_data_oe),
        .data_in(right_data_in),
        .collision_n(rgt_coll_any)
    );
endmodule // dpcl_host

// >>> design/dpcl_pkg.sv
/*
 * Shared constants and types for the dual-port coordination host controller.
 * Assumes a single 50 MHz clock; pin timing figures are converted to cycles here.
 */
package dpcl_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 9;
    localparam int BANKS = 2;
    localparam int CNT_W = 4;
    localparam logic [15:0] LEFT_MAILBOX_ADDR = 16'hFFFE;
    localparam logic [15:0] RIGHT_MAILBOX_ADDR = 16'hFFFF;
    localparam logic [8:0] DATA_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] SYNC_STAGES = 4'h2;
    // Least times: collision settle, read access, write pulse width
    localparam int COLL_SETTLE_NS = 20;
    localparam int ACCESS_NS = 20;
    localparam int WRITE_PULSE_NS = 20;

    function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] SETTLE_CYCLES = ns_to_cycles(COLL_SETTLE_NS) + SYNC_STAGES;
    localparam logic [CNT_W-1:0] ACCESS_CYCLES = ns_to_cycles(ACCESS_NS) + SYNC_STAGES;
    localparam logic [CNT_W-1:0] PULSE_CYCLES = ns_to_cycles(WRITE_PULSE_NS);

    typedef enum logic [1:0] {
        DPCL_MEM_READ,
        DPCL_MEM_WRITE,
        DPCL_TOKEN_READ,
        DPCL_TOKEN_WRITE
    } dpcl_cmd_type;
endpackage

// >>> design/dpcl_port_seq.sv
/*
 * One port access sequencer: turns a command into pin cycles on one side of the memory.
 * Assumes data and collision pins are asynchronous; both pass two flip-flops here.
 */
`timescale 1ns/1ps
module dpcl_port_seq
    import dpcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dpcl_cmd_type cmd_kind,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic write_stalled,
    output logic enable_n,
    output logic write_select_n,
    output logic out_enable_n,
    output logic token_select_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic collision_n
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_HOLD, ST_STROBE, ST_READ, ST_RELEASE
    } dpcl_seq_type;

    dpcl_seq_type state;
    dpcl_cmd_type kind;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] data_meta, data_sync;
    logic coll_meta, coll_sync;

    always_ff @(posedge ref_clk) begin
        data_meta <= data_in;
        data_sync <= data_meta;
        coll_meta <= collision_n;
        coll_sync <= coll_meta;
    end

    assign cmd_ready = (state == ST_IDLE);
    assign write_stalled = (state == ST_HOLD) && !coll_sync;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            kind <= DPCL_MEM_READ;
            cnt <= CNT_ZERO;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        kind <= cmd_kind;
                        cnt <= SETTLE_CYCLES;
                        state <= ST_SETUP;
                    end
                end
                // Address and selects stand until the collision answer has settled
                ST_SETUP: begin
                    if (cnt == CNT_ONE) begin
                        if (kind == DPCL_MEM_WRITE) begin
                            state <= ST_HOLD;
                        end else if (kind == DPCL_TOKEN_WRITE) begin
                            cnt <= PULSE_CYCLES;
                            state <= ST_STROBE;
                        end else begin
                            cnt <= ACCESS_CYCLES;
                            state <= ST_READ;
                        end
                    end else begin
                        cnt <= cnt - CNT_ONE;
                    end
                end
                // A write under a low collision would be discarded, so wait it out
                ST_HOLD: begin
                    if (coll_sync) begin
                        cnt <= PULSE_CYCLES;
                        state <= ST_STROBE;
                    end
                end
                ST_STROBE, ST_READ: begin
                    if (cnt == CNT_ONE) begin
                        state <= ST_RELEASE;
                    end else begin
                        cnt <= cnt - CNT_ONE;
                    end
                end
                // One idle cycle keeps token select and output enable high between reads and drops data_oe
                ST_RELEASE: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin drive
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enable_n <= 1'b1;
            write_select_n <= 1'b1;
            out_enable_n <= 1'b1;
            token_select_n <= 1'b1;
            addr <= '0;
            data_out <= DATA_ZERO;
            data_oe <= 1'b0;
        end else if (state == ST_IDLE && cmd_valid) begin
            addr <= cmd_addr;
            // Token accesses use the token select as chip select
            token_select_n <= !(cmd_kind inside {DPCL_TOKEN_READ, DPCL_TOKEN_WRITE});
            enable_n <= !(cmd_kind inside {DPCL_MEM_READ, DPCL_MEM_WRITE});
            // Reads drive output enable low; a memory read of our own mailbox also clears it
            out_enable_n <= !(cmd_kind inside {DPCL_MEM_READ, DPCL_TOKEN_READ});
            // Tokens take only bit 0 on a write
            data_out <= (cmd_kind == DPCL_TOKEN_WRITE) ? {8'h00, cmd_data[0]} : cmd_data;
            data_oe <= (cmd_kind inside {DPCL_MEM_WRITE, DPCL_TOKEN_WRITE});
        end else if (state == ST_HOLD && coll_sync) begin
            write_select_n <= 1'b0;
        end else if (state == ST_SETUP && cnt == CNT_ONE && kind == DPCL_TOKEN_WRITE) begin
            write_select_n <= 1'b0;
        end else if ((state == ST_STROBE || state == ST_READ) && cnt == CNT_ONE) begin
            write_select_n <= 1'b1;
            enable_n <= 1'b1;
            out_enable_n <= 1'b1;
            token_select_n <= 1'b1;
        end else if (state == ST_RELEASE) begin
            data_oe <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= DATA_ZERO;
        end else begin
            rsp_valid <= (state == ST_STROBE || state == ST_READ) && cnt == CNT_ONE;
            if (state == ST_READ && cnt == CNT_ONE) begin
                rsp_data <= data_sync;
            end
        end
    end
endmodule // dpcl_port_seq

// >>> tb/dpcl_dev_model.sv
/* Behavioural model of the memory's coordination side: mailboxes, master arbitration, tokens.
   Assumes pins move on rising edges only; the model looks at falling edges. */
`timescale 1ns/1ps
module dpcl_dev_model
    import dpcl_pkg::*;
(
    input wire logic clk,
    input wire logic role_select,
    input wire logic [1:0] en_n,
    input wire logic [1:0] wr_n,
    input wire logic [1:0] oe_n,
    input wire logic [1:0] ts_n,
    input wire logic [1:0] doe,
    input wire logic [1:0][ADDR_W-1:0] adr,
    input wire logic [1:0][DATA_W-1:0] dout,
    output logic [1:0][DATA_W-1:0] dq,
    output logic [1:0] coll_n,
    output logic [1:0] mbox_n
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [1:0] own [8];
    logic [1:0] req [8];
    logic [ADDR_W:0] prev [2];
    logic [1:0] busy, tq, tlat;
    int k;

    assign coll_n = role_select ? ~busy : 2'h3;
    initial begin
        foreach (own[i]) begin
            own[i] = 2'h0;
            req[i] = 2'h0;
        end
        prev = '{17'h1FFFF, 17'h1FFFF};
        busy = 2'h0;
        tq = 2'h3;
        tlat = 2'h0;
        // Power-up level is undefined, so start with both flags raised
        mbox_n = 2'h0;
        dq = '0;
    end
    always @(negedge clk) begin
        if (en_n[0] || en_n[1] || adr[0] != adr[1]) begin
            busy = 2'h0;
        end else if (busy == 2'h0) begin
            // Later side loses; a tie always goes against the right port
            busy = ({en_n[1], adr[1]} != prev[1]) ? 2'h2 : 2'h1;
        end
        for (int s = 0; s < 2; s++) begin
            k = int'(adr[s][2:0]);
            // A slave takes its write inhibit from the pin level alone
            if (!en_n[s] && !wr_n[s] && (role_select ? !busy[s] : coll_n[s])) begin
                mem[adr[s]] = dout[s];
                if (adr[s] == (s ? LEFT_MAILBOX_ADDR : RIGHT_MAILBOX_ADDR)) begin
                    mbox_n[1 - s] = 1'b0;
                end
            end
            if (!en_n[s] && !oe_n[s]
                    && adr[s] == (s ? RIGHT_MAILBOX_ADDR : LEFT_MAILBOX_ADDR)) begin
                mbox_n[s] = 1'b1;
            end
            if (!ts_n[s] && !wr_n[s]) begin
                if (!dout[s][0]) begin
                    if (own[k] == 2'h0) own[k] = 2'(s + 1);
                    else if (own[k] != 2'(s + 1)) req[k][s] = 1'b1;
                end else if (own[k] == 2'(s + 1)) begin
                    own[k] = req[k][1 - s] ? 2'(2 - s) : 2'h0;
                    req[k][1 - s] = 1'b0;
                end else begin
                    req[k][s] = 1'b0;
                end
            end
            if (!ts_n[s] && !oe_n[s]) begin
                if (!tlat[s]) tq[s] = own[k] != 2'(s + 1);
                tlat[s] = 1'b1;
            end else begin
                tlat[s] = 1'b0;
            end
            if (doe[s]) dq[s] = dout[s];
            else if (tlat[s]) dq[s] = {DATA_W{tq[s]}};
            else if (!en_n[s] && !oe_n[s])
                dq[s] = mem.exists(adr[s]) ? mem[adr[s]] : ~adr[s][8:0];
            else dq[s] = ~dq[s]; // Released lines must not keep the last value
            prev[s] = {en_n[s], adr[s]};
        end
    end
endmodule // dpcl_dev_model

// >>> tb/dpcl_host_sva.sv
/* Checker for dpcl_host pin behaviour; bound to the top module.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module dpcl_host_sva
    import dpcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic init_done,
    input wire logic lft_cmd_ready,
    input wire logic rgt_cmd_ready,
    input wire logic role_select,
    input wire logic left_enable_n,
    input wire logic left_write_select_n,
    input wire logic left_out_enable_n,
    input wire logic left_token_select_n,
    input wire logic [ADDR_W-1:0] left_addr,
    input wire logic left_data_oe,
    input wire logic [BANKS-1:0] left_collision_n,
    input wire logic right_enable_n,
    input wire logic right_write_select_n,
    input wire logic right_out_enable_n,
    input wire logic right_token_select_n,
    input wire logic [ADDR_W-1:0] right_addr,
    input wire logic [BANKS-1:0] right_collision_n
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_master; role_select; endproperty
    a_master: assert property (p_master) else $error("role select low");
    property p_lock; !init_done |-> !lft_cmd_ready && !rgt_cmd_ready; endproperty
    a_lock: assert property (p_lock) else $error("ready before init");
    property p_lclr;
        $fell(left_enable_n) && !init_done |-> left_addr == LEFT_MAILBOX_ADDR
            && !left_out_enable_n;
    endproperty
    a_lclr: assert property (p_lclr) else $error("left init read wrong");
    property p_rclr;
        $fell(right_enable_n) && !init_done |-> right_addr == RIGHT_MAILBOX_ADDR
            && !right_out_enable_n && right_write_select_n;
    endproperty
    a_rclr: assert property (p_rclr) else $error("right init read wrong");
    property p_lset;
        $fell(left_write_select_n) && !left_enable_n |-> !$past(left_enable_n, 2)
            && $stable(left_addr);
    endproperty
    a_lset: assert property (p_lset) else $error("left write too early");
    property p_rset;
        $fell(right_write_select_n) && !right_enable_n |-> $past(&right_collision_n, 3);
    endproperty
    a_rset: assert property (p_rset) else $error("right write before settle");
    property p_lblk;
        (!(&left_collision_n))[*5] |-> left_write_select_n || !left_token_select_n;
    endproperty
    a_lblk: assert property (p_lblk) else $error("left write in collision");
    property p_rblk;
        (!(&right_collision_n))[*5] |-> right_write_select_n || !right_token_select_n;
    endproperty
    a_rblk: assert property (p_rblk) else $error("right write in collision");
    property p_trd;
        !left_token_select_n && !left_out_enable_n |-> left_enable_n && !left_data_oe;
    endproperty
    a_trd: assert property (p_trd) else $error("token read selects wrong");
endmodule // dpcl_host_sva

bind dpcl_host dpcl_host_sva u_sva (.ref_clk, .rst_n, .init_done, .lft_cmd_ready,
    .rgt_cmd_ready, .role_select, .left_enable_n, .left_write_select_n, .left_out_enable_n,
    .left_token_select_n, .left_addr, .left_data_oe, .left_collision_n, .right_enable_n,
    .right_write_select_n, .right_out_enable_n, .right_token_select_n, .right_addr,
    .right_collision_n);

// >>> tb/dpcl_host_tb.sv
/* Self-checking bench for dpcl_host with the device model on both ports.
   Assumes the model answers on falling edges and collision bank 1 is driven here. */
`timescale 1ns/1ps
module dpcl_host_tb
    import dpcl_pkg::*;
;
    logic ref_clk, rst_n, init_done, role_select;
    logic [1:0] vld, rdy, rv, stl, pend, cb;
    dpcl_cmd_type knd [2];
    logic [ADDR_W-1:0] adr [2];
    logic [DATA_W-1:0] dat [2], rd [2];
    logic left_enable_n, left_write_select_n, left_out_enable_n, left_token_select_n, left_data_oe;
    logic right_enable_n, right_write_select_n, right_out_enable_n, right_token_select_n;
    logic right_data_oe;
    logic [ADDR_W-1:0] left_addr, right_addr;
    logic [DATA_W-1:0] left_data_out, right_data_out;
    wire [DATA_W-1:0] left_data_in, right_data_in;
    wire [1:0] coll;
    wire left_mailbox_flag_n, right_mailbox_flag_n;
    wire [BANKS-1:0] left_collision_n = {cb[0], coll[0]};
    wire [BANKS-1:0] right_collision_n = {cb[1], coll[1]};
    int miscompares = 0;
    int checks_done = 0;

    dpcl_host dut (.ref_clk, .rst_n, .init_done, .role_select,
        .lft_cmd_valid(vld[0]), .lft_cmd_ready(rdy[0]), .lft_cmd_kind(knd[0]),
        .lft_cmd_addr(adr[0]), .lft_cmd_data(dat[0]), .lft_rsp_valid(rv[0]),
        .lft_rsp_data(rd[0]), .lft_write_stalled(stl[0]), .lft_mail_pending(pend[0]),
        .rgt_cmd_valid(vld[1]), .rgt_cmd_ready(rdy[1]), .rgt_cmd_kind(knd[1]),
        .rgt_cmd_addr(adr[1]), .rgt_cmd_data(dat[1]), .rgt_rsp_valid(rv[1]),
        .rgt_rsp_data(rd[1]), .rgt_write_stalled(stl[1]), .rgt_mail_pending(pend[1]),
        .left_enable_n, .left_write_select_n, .left_out_enable_n, .left_token_select_n,
        .left_addr, .left_data_out, .left_data_oe, .left_data_in, .left_collision_n,
        .left_mailbox_flag_n, .right_enable_n, .right_write_select_n, .right_out_enable_n,
        .right_token_select_n, .right_addr, .right_data_out, .right_data_oe, .right_data_in,
        .right_collision_n, .right_mailbox_flag_n);
    dpcl_dev_model dev (.clk(ref_clk), .role_select,
        .en_n({right_enable_n, left_enable_n}), .wr_n({right_write_select_n, left_write_select_n}),
        .oe_n({right_out_enable_n, left_out_enable_n}), .doe({right_data_oe, left_data_oe}),
        .ts_n({right_token_select_n, left_token_select_n}), .adr({right_addr, left_addr}),
        .dout({right_data_out, left_data_out}), .dq({right_data_in, left_data_in}),
        .coll_n(coll), .mbox_n({right_mailbox_flag_n, left_mailbox_flag_n}));

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic go(input int p, input dpcl_cmd_type k, input logic [15:0] a,
                      input logic [8:0] d);
        int n;
        knd[p] = k;
        adr[p] = a;
        dat[p] = d;
        vld[p] = 1'b1;
        for (n = 0; !rdy[p] && n < 200; n++) tick(1);
        tick(1);
        vld[p] = 1'b0;
        for (n = 0; !rv[p] && n < 200; n++) tick(1);
        if (!rv[p]) begin
            miscompares++;
            $display("mismatch at %0t: no answer on port %0d", $time, p);
            end_sim();
        end
    endtask
    task automatic t_init();
        for (int n = 0; init_done !== 1'b1 && n < 100; n++) tick(1);
        if (init_done !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: init never finished", $time);
            end_sim();
        end
        tick(6);
        chk(9'({right_mailbox_flag_n, left_mailbox_flag_n}), 9'h003);
        chk(9'(pend), 9'h000);
    endtask
    task automatic t_mail();
        logic [15:0] a;
        for (int s = 0; s < 2; s++) begin
            a = s ? RIGHT_MAILBOX_ADDR : LEFT_MAILBOX_ADDR;
            go(1 - s, DPCL_MEM_WRITE, a, 9'h1A5 ^ 9'(s));
            tick(6);
            chk(9'(pend[s]), 9'h001);
            go(s, DPCL_MEM_READ, a, 9'h000);
            chk(rd[s], 9'h1A5 ^ 9'(s));
            tick(6);
            chk(9'(pend[s]), 9'h000);
        end
    endtask
    task automatic t_token();
        // Per step: writing port, bit written, then left and right read values
        logic [39:0] seq;
        logic [3:0] e;
        seq = 40'h1962D7AF17;
        for (int i = 0; i < 8; i++) begin
            for (int j = 9; j >= 0; j--) begin
                e = seq[j*4 +: 4];
                go(int'(e[3]), DPCL_TOKEN_WRITE, {13'h1ABC, 3'(i)}, {8'hFF, e[2]});
                go(0, DPCL_TOKEN_READ, 16'(i), 9'h000);
                chk(rd[0], {9{e[1]}});
                go(1, DPCL_TOKEN_READ, 16'(i), 9'h000);
                chk(rd[1], {9{e[0]}});
            end
        end
    endtask
    task automatic t_coll();
        fork
            go(0, DPCL_MEM_WRITE, 16'h2345, 9'h1AA);
            go(1, DPCL_MEM_WRITE, 16'h2345, 9'h055);
        join
        go(0, DPCL_MEM_READ, 16'h2345, 9'h000);
        chk(rd[0], 9'h055);
        // A low far bank stalls each port's write in turn
        for (int p = 0; p < 2; p++) begin
            cb[p] = 1'b0;
            fork
                go(p, DPCL_MEM_WRITE, 16'h0100 + 16'(p), 9'h0C3 ^ 9'(p));
                begin
                    tick(12);
                    chk(9'(stl[p]), 9'h001);
                    cb[p] = 1'b1;
                end
            join
            go(1 - p, DPCL_MEM_READ, 16'h0100 + 16'(p), 9'h000);
            chk(rd[1 - p], 9'h0C3 ^ 9'(p));
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        rst_n = 1'b0;
        vld = 2'h0;
        cb = 2'h3;
        knd = '{DPCL_MEM_READ, DPCL_MEM_READ};
        adr = '{16'h0000, 16'h0000};
        dat = '{9'h000, 9'h000};
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_init();
        t_mail();
        t_token();
        t_coll();
        end_sim();
    end
endmodule // dpcl_host_tb
